// ---- include/ahb_port_defs.vh ----
// Operation
// - device asserts wait while access cannot complete
// - interface type latched at reset release
// - accept select, shared high enable, write, read
// - 16-bit data bus, 17-bit address input
// - memory select steers to registers or memory
// - hold wait until data valid or accepted
// - high enable plus address bit 0 steer bytes
// - wait polarity strap latched at reset
`ifndef AHB_PORT_DEFS_VH
`define AHB_PORT_DEFS_VH
`define AHB_ADDR_W 17
`define AHB_DATA_W 16
`define AHB_MODE_W 3
`define AHB_MODE_GENERIC2 3'h4
`define AHB_ARB_LAT 4'h3
`define AHB_CNT_W 4
`endif

// ---- rtl/ahb_port.v ----
`timescale 1ns/1ps
`include "ahb_port_defs.vh"
module ahb_port (
   clk,
   reset_n,
   lcd_window_select_n,
   rd_n,
   low_byte_write_enable_n,
   high_byte_enable_n,
   mem_reg_select,
   bus_start_n,
   rd_wr_n,
   device_address_bus,
   device_data_bus_in,
   device_data_bus_out,
   device_data_bus_oe,
   mode_strap,
   wait_polarity_strap,
   wait_out,
   wait_oe,
   mode_ok,
   int_req,
   int_mem_sel,
   int_write,
   int_addr,
   int_wdata,
   int_be,
   int_ack,
   int_rdata
);
   input wire clk;
   input wire reset_n;
   input wire lcd_window_select_n;
   input wire rd_n;
   input wire low_byte_write_enable_n;
   input wire high_byte_enable_n;
   input wire mem_reg_select;
   input wire bus_start_n;
   input wire rd_wr_n;
   input wire [`AHB_ADDR_W-1:0] device_address_bus;
   input wire [`AHB_DATA_W-1:0] device_data_bus_in;
   output reg [`AHB_DATA_W-1:0] device_data_bus_out;
   output wire device_data_bus_oe;
   input wire [`AHB_MODE_W-1:0] mode_strap;
   input wire wait_polarity_strap;
   output wire wait_out;
   output wire wait_oe;
   output wire mode_ok;
   output wire int_req;
   output reg int_mem_sel;
   output reg int_write;
   output reg [`AHB_ADDR_W-1:0] int_addr;
   output reg [`AHB_DATA_W-1:0] int_wdata;
   output reg [1:0] int_be;
   input wire int_ack;
   input wire [`AHB_DATA_W-1:0] int_rdata;

   localparam ST_IDLE = 4'h1;
   localparam ST_REQ = 4'h2;
   localparam ST_DONE = 4'h4;
   localparam ST_END = 4'h8;

   // port behaviour in brief:
   // - an access opens when the synced select is low with exactly one
   //   strobe low, the port was strapped for this bus type, and the two
   //   unused pins sit high
   // - the edge that takes the access raises the wait indication and the
   //   internal request together, so the host never sees a gap
   // - address, byte lanes, direction, memory select and write data are
   //   captured once at the take edge; the host holds them until release
   // - the internal side answers with an acknowledge; the latency counter
   //   keeps the request up for a minimum arbitration time as well
   // - read data is registered on the acknowledge edge and stays on the
   //   output register until the next read replaces it
   // - wait is released one edge after the data register was loaded, so
   //   read data is settled before the host can end its cycle
   // - the sequencer then parks in its end state until the host has
   //   raised select, which stops one long select from opening two cycles
   // - both strobes low at once is treated as no access at all
   // - straps are static board levels; they are caught on the first edge
   //   after reset and never looked at again by the sequencer
   // - until that first edge the wait pin shows the released level for
   //   the strap as it stands, so no false wait appears during reset
   //
   // limitations:
   // - the synchroniser adds two edges of lag on every control pin, so a
   //   host strobe shorter than one clock period can be missed
   // - the data and address pins are not synchronised; they are only
   //   read at the take edge, which is well after they became stable
   // - no burst support: each access needs select to go high in between
   // - the wait enable is always on; an open-drain board would have to
   //   gate the pin outside this block
   //
   // byte lanes (bit 1 high byte, bit 0 low byte):
   // - high enable low, even address: both lanes
   // - odd address: high lane only
   // - high enable high, even address: low lane only
   //
   // wait polarity:
   // - strap high: the pin is high while waiting
   // - strap low: the pin is low while waiting

   reg [5:0] sync1_ff;
   reg [5:0] sync2_ff;
   wire [5:0] pin_raw;
   reg [`AHB_MODE_W-1:0] mode_ff;
   reg wait_pol_ff;
   reg strap_taken_ff;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg wait_ff;
   reg [`AHB_CNT_W-1:0] lat_ff;
   wire cs_s, rd_s, wr_s, hbe_s, idle_s;
   wire access_s;

   // raw control pins, one bit per synchroniser lane
   assign pin_raw = {rd_wr_n, bus_start_n, high_byte_enable_n,
      low_byte_write_enable_n, rd_n, lcd_window_select_n};

   // control pins are asynchronous to clk; two stages before any logic
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_ff[gi] <= 1'b1; // idle level of every pin is high
               sync2_ff[gi] <= 1'b1;
            end else begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   // decoded control levels, all taken from the second stage
   assign cs_s = ~sync2_ff[0];
   assign rd_s = ~sync2_ff[1];
   assign wr_s = ~sync2_ff[2];
   assign hbe_s = ~sync2_ff[3];
   assign idle_s = sync2_ff[4] & sync2_ff[5]; // unused pins tied high by host
   // read and write together is illegal; treat as no access
   assign access_s = cs_s & (rd_s ^ wr_s);

   // straps caught on first edge after reset release
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= 3'h0;
         wait_pol_ff <= 1'b0;
         strap_taken_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         mode_ff <= mode_strap;
         wait_pol_ff <= wait_polarity_strap;
         strap_taken_ff <= 1'b1;
      end
   end
   // port only serves once generic #2 mode was strapped
   assign mode_ok = strap_taken_ff & (mode_ff == `AHB_MODE_GENERIC2) & idle_s;

   // cycle sequencer: wait asserted from select until data ready
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (mode_ok && access_s) nxt_state = ST_REQ;
         ST_REQ: if (int_ack && lat_ff == 4'h0) nxt_state = ST_DONE;
         ST_DONE: nxt_state = ST_END;
         ST_END: if (!cs_s) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         wait_ff <= 1'b0;
         lat_ff <= 4'h0;
         int_mem_sel <= 1'b0;
         int_write <= 1'b0;
         int_addr <= 17'h00000;
         int_wdata <= 16'h0000;
         int_be <= 2'h0;
         device_data_bus_out <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE && nxt_state == ST_REQ) begin
            // capture is safe: host holds bus until release
            wait_ff <= 1'b1;
            lat_ff <= `AHB_ARB_LAT;
            int_mem_sel <= mem_reg_select;
            int_write <= wr_s;
            int_addr <= device_address_bus;
            int_wdata <= device_data_bus_in;
            // 16-bit needs even address; 8-bit picks lane by bit 0
            int_be <= hbe_s ? (device_address_bus[0] ? 2'h2 : 2'h3)
               : (device_address_bus[0] ? 2'h2 : 2'h1);
         end else if (state_ff == ST_REQ) begin
            if (lat_ff != 4'h0)
               lat_ff <= lat_ff - 4'h1;
            if (nxt_state == ST_DONE) begin
               if (!int_write)
                  device_data_bus_out <= int_rdata;
            end
         end else if (state_ff == ST_DONE) begin
            wait_ff <= 1'b0;
         end
      end
   end

   // internal request held for whole arbitration phase
   assign int_req = (state_ff == ST_REQ);
   assign device_data_bus_oe = cs_s & rd_s & ~int_write & (state_ff != ST_IDLE);
   // before the strap is caught, show the released level for the live strap
   assign wait_out = strap_taken_ff ? (wait_ff ^ ~wait_pol_ff)
      : ~wait_polarity_strap;
   assign wait_oe = 1'b1;
endmodule // ahb_port

// ---- sim/ahb_port_assertions.sv ----
`timescale 1ns/1ps
module ahb_port_assertions(input wire clk, reset_n, lcd_window_select_n,
   low_byte_write_enable_n, high_byte_enable_n, mem_reg_select, wait_polarity_strap,
   wait_out, int_req, int_mem_sel, int_write, mode_ok,
   input wire [16:0] device_address_bus, input wire [1:0] int_be);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
// waiting level follows the strap
wire wt = wait_out == wait_polarity_strap;
sequence held_wait; wt [*3]; endsequence
a_wait_rise: assert property ($rose(int_req) |-> $rose(wt)) else $error("wait late");
a_wait_hold: assert property (int_req |-> wt) else $error("wait dropped");
a_wait_span: assert property ($rose(int_req) |-> held_wait ##[1:12] !wt)
   else $error("wait span");
a_mode_gate: assert property (!mode_ok |-> !$rose(int_req)) else $error("bad mode");
a_mem_steer: assert property (int_req |-> int_mem_sel == mem_reg_select)
   else $error("steer");
a_write_dir: assert property (int_req |-> int_write != low_byte_write_enable_n)
   else $error("direction");
a_byte_steer: assert property ($rose(int_req) |-> int_be == (device_address_bus[0] ?
   2'h2 : high_byte_enable_n ? 2'h1 : 2'h3)) else $error("lanes");
a_idle_level: assert property (lcd_window_select_n [*4] |-> !wt) else $error("idle");
endmodule // ahb_port_assertions

// ---- sim/ahb_host.sv ----
`timescale 1ns/1ps
module ahb_host(input wire clk, wait_out, wait_polarity_strap,
   output logic lcd_window_select_n = 1, rd_n = 1, low_byte_write_enable_n = 1,
   high_byte_enable_n = 1, mem_reg_select = 0, output logic [16:0] device_address_bus = 0,
   output logic [15:0] device_data_bus_in = 0);
int hang = 0;
// one access, all held until wait lets go
task cyc(input logic w, hb, mr, input logic [16:0] a, input logic [15:0] d);
   int n;
   @(negedge clk);
   {mem_reg_select, device_address_bus, device_data_bus_in} <= {mr, a, w ? d : ~d};
   high_byte_enable_n <= hb;
   lcd_window_select_n <= 0;
   if (w) low_byte_write_enable_n <= 0; else rd_n <= 0;
   n = 0;
   do begin @(negedge clk); n++; end while (wait_out != wait_polarity_strap && n < 20);
   do begin @(negedge clk); n++; end while (wait_out == wait_polarity_strap && n < 40);
   if (n >= 40) hang++;
   {lcd_window_select_n, rd_n, low_byte_write_enable_n} <= 3'h7;
   device_data_bus_in <= ~device_data_bus_in; // no stale value once released
   repeat (3) @(negedge clk);
endtask
endmodule // ahb_host

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
logic clk = 0, reset_n = 0, bus_start_n = 1, rd_wr_n = 1, wait_polarity_strap = 0, int_ack = 0;
logic [2:0] mode_strap = 3'h4;
wire lcd_window_select_n, rd_n, low_byte_write_enable_n, high_byte_enable_n, mem_reg_select;
wire device_data_bus_oe, wait_out, wait_oe, mode_ok, int_req, int_mem_sel, int_write;
wire [16:0] device_address_bus, int_addr;
wire [15:0] device_data_bus_in, device_data_bus_out, int_wdata;
wire [15:0] int_rdata = int_addr[15:0] ^ 16'h5A5A;
wire [1:0] int_be;
logic [16:0] a;
logic [15:0] wd_s;
logic [1:0] be_s;
// {high enable, a0, expected lanes}
logic [3:0] rows [4] = '{4'h3, 4'h6, 4'h9, 4'hE};
int err_total = 0, total_checks = 0, reqs = 0, n = 0, cyc_n = 0;
ahb_port ahb_port_inst(.clk(clk), .reset_n(reset_n), .lcd_window_select_n(lcd_window_select_n),
   .rd_n(rd_n), .low_byte_write_enable_n(low_byte_write_enable_n),
   .high_byte_enable_n(high_byte_enable_n), .mem_reg_select(mem_reg_select),
   .bus_start_n(bus_start_n), .rd_wr_n(rd_wr_n), .device_address_bus(device_address_bus),
   .device_data_bus_in(device_data_bus_in), .device_data_bus_out(device_data_bus_out),
   .device_data_bus_oe(device_data_bus_oe), .mode_strap(mode_strap),
   .wait_polarity_strap(wait_polarity_strap), .wait_out(wait_out), .wait_oe(wait_oe),
   .mode_ok(mode_ok), .int_req(int_req), .int_mem_sel(int_mem_sel), .int_write(int_write),
   .int_addr(int_addr), .int_wdata(int_wdata), .int_be(int_be), .int_ack(int_ack),
   .int_rdata(int_rdata));
ahb_host ahb_host_inst(.clk(clk), .wait_out(wait_out), .wait_polarity_strap(wait_polarity_strap),
   .lcd_window_select_n(lcd_window_select_n), .rd_n(rd_n),
   .low_byte_write_enable_n(low_byte_write_enable_n), .high_byte_enable_n(high_byte_enable_n),
   .mem_reg_select(mem_reg_select), .device_address_bus(device_address_bus),
   .device_data_bus_in(device_data_bus_in));
always #4 clk = ~clk;
// memory side answers half a cycle after each request, on the next falling edge
always @(negedge clk) int_ack <= int_req;
always @(posedge clk) if (int_req) {be_s, wd_s} <= {int_be, int_wdata};
always @(posedge int_req) reqs++;
always @(posedge clk) if (++cyc_n > 2000) begin err_total++; complete_run; end
task chk(input logic [31:0] got, exp);
   total_checks++;
   if (got !== exp) begin err_total++; $display("BAD %0t %h %h", $time, got, exp); end
endtask
task rst(input logic p);
   @(negedge clk);
   {reset_n, wait_polarity_strap} = {1'h0, p};
   repeat (12) @(negedge clk);
   reset_n = 1;
   repeat (2) @(negedge clk);
endtask
task complete_run;
   err_total += ahb_host_inst.hang;
   $display("checks %0d errors %0d", total_checks, err_total);
   if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
   else $display("Run complete: FAIL");
   $finish;
endtask
initial begin
   rst(0);
   chk(wait_out, 1);
   chk(mode_ok, 1);
   for (int i = 0; i < 4; i++) begin
      a = 17'h10F0 | rows[i][2];
      ahb_host_inst.cyc(1, rows[i][3], i[0], a, 16'hC3A0 + i);
      chk(be_s, rows[i][1:0]);
      chk(wd_s, 16'hC3A0 + i);
      chk(int_addr, a);
      ahb_host_inst.cyc(0, rows[i][3], i[0], a, 0);
      chk(device_data_bus_out, a[15:0] ^ 16'h5A5A);
      chk(device_data_bus_oe, 0);
      chk(wait_oe, 1);
   end
   $display("rows done");
   bus_start_n = 0;
   repeat (4) @(negedge clk);
   chk(mode_ok, 0);
   n = reqs;
   ahb_host_inst.cyc(1, 0, 0, 0, 0);
   chk(reqs, n);
   bus_start_n = 1;
   $display("refusal done");
   mode_strap = 3'h0;
   rst(0);
   chk(mode_ok, 0);
   mode_strap = 3'h4;
   rst(1);
   chk(wait_out, 0);
   ahb_host_inst.cyc(0, 0, 1, 17'h1FFFE, 0);
   chk(device_data_bus_out, 16'hA5A4);
   $display("polarity done");
   complete_run;
end
endmodule // testbench
bind ahb_port ahb_port_assertions ahb_port_assertions_inst(.clk(clk), .reset_n(reset_n),
   .lcd_window_select_n(lcd_window_select_n), .low_byte_write_enable_n(low_byte_write_enable_n),
   .high_byte_enable_n(high_byte_enable_n), .mem_reg_select(mem_reg_select),
   .wait_polarity_strap(wait_polarity_strap), .wait_out(wait_out), .int_req(int_req),
   .int_mem_sel(int_mem_sel), .int_write(int_write), .mode_ok(mode_ok),
   .device_address_bus(device_address_bus), .int_be(int_be));
